// >>> core/etc_timer.sv
`timescale 1ns/100ps

// What this block does
// - in timer mode without the prescaler the count advances once per instruction cycle.
// - a software write to the count holds off counting for two instruction cycles.
// - in counter mode the count advances on the chosen edge of the external input.
// - clock_select at one picks counter mode fed by the external input.
// - the one prescaler serves the timer when prescaler_assign is zero, else the watchdog.
// - with the prescaler on the timer, prescale_ratio picks one of eight ratios from 1:2 to 1:256.
// - a 1:1 rate comes only from giving the prescaler to the watchdog.
// - the prescaler is hidden from software and a count write clears it while it serves the timer.
// - every roll from FFh to 00h sets overflow_flag whatever the enable.
// - only a software write clears overflow_flag.
// - a timer interrupt is requested while overflow_flag and overflow_irq_enable are both set.
// - in counter mode the prescaled input is taken into the count only on the Q2 and Q4 phases.
// - during sleep counting stops and the count keeps its value.
module etc_timer #(
  parameter int PRESCALE_WIDTH = 8
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external count pin
  input wire logic external_count_input,
  // processor state
  input wire logic sleep_mode,
  // watchdog side
  input wire logic watchdog_tick,
  input wire logic watchdog_clear,
  output logic watchdog_event,
  // interrupts
  output logic timer_irq,
  output logic irq
);

  etc_pkg::etc_apb_req_type req;
  etc_pkg::etc_option_type option_config;
  logic [7:0] count_register;
  logic [7:0] interrupt_control;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [1:0] phase;
  logic [1:0] inhibit;
  logic pending;

  // bus decode
  wire setup_phase;
  wire access_phase;
  wire wr_access;
  wire rd_access;
  wire hit_count;
  wire hit_option;
  wire hit_intctl;
  wire hit_status;
  wire hit_mask;
  wire mapped;
  wire count_write;
  wire [7:0] read_mux;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                 wdata: pwdata};
  assign setup_phase = req.sel & ~req.enable;
  assign access_phase = req.sel & req.enable & pready;
  assign wr_access = access_phase & req.write;
  assign rd_access = access_phase & ~req.write;
  assign hit_count = req.addr == etc_pkg::COUNT_OFFSET;
  assign hit_option = req.addr == etc_pkg::OPTION_OFFSET;
  assign hit_intctl = req.addr == etc_pkg::INTCTL_OFFSET;
  assign hit_status = req.addr == etc_pkg::STATUS_OFFSET;
  assign hit_mask = req.addr == etc_pkg::MASK_OFFSET;
  assign mapped = hit_count | hit_option | hit_intctl | hit_status | hit_mask;
  assign count_write = wr_access & hit_count;

  assign read_mux = hit_count ? count_register :
                    hit_option ? option_config :
                    hit_intctl ? interrupt_control :
                    hit_status ? irq_status :
                    hit_mask ? irq_mask : 8'h00;

  // instruction cycle phases
  wire q2;
  wire q4;
  wire inst_tick;

  assign q2 = phase == etc_pkg::PHASE_Q2;
  assign q4 = phase == etc_pkg::PHASE_Q4;
  assign inst_tick = q4;

  // event routing
  wire ext_edge;
  wire to_timer;
  wire src_event;
  wire psc_in;
  wire psc_clear;
  wire psc_out;
  wire timer_event;
  wire apply;
  wire step;
  wire overflow;

  etc_edge_sync u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(external_count_input),
    .falling(option_config.edge_select),
    .edge_seen(ext_edge)
  );

  assign to_timer = ~option_config.prescaler_assign;
  assign src_event = option_config.clock_select ? ext_edge : inst_tick;
  assign psc_in = ~sleep_mode & (to_timer ? src_event : watchdog_tick);
  assign psc_clear = to_timer ? count_write : watchdog_clear;

  etc_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(psc_clear),
    .event_in(psc_in),
    .ratio(option_config.prescale_ratio),
    .event_out(psc_out)
  );

  // undivided path when the prescaler serves the watchdog
  assign timer_event = ~sleep_mode & (to_timer ? psc_out : src_event);

  // counter mode waits for a q2 or q4 sample
  assign apply = option_config.clock_select ? (pending & (q2 | q4)) :
                 timer_event;
  assign step = apply & ~sleep_mode & (inhibit == 2'h0) & ~count_write;
  assign overflow = step & (count_register == etc_pkg::COUNT_TOP);

  // next values
  logic [7:0] next_count;
  logic [7:0] next_intctl;
  logic [7:0] next_status;
  logic [1:0] next_inhibit;
  logic next_pending;
  logic [7:0] events;

  assign events = {6'h00, ext_edge & option_config.clock_select, overflow};

  always_comb
  begin
    next_count = count_register;
    if (count_write)
      next_count = pwdata[7:0];
    else if (step)
      next_count = count_register + 8'h01;
  end

  always_comb
  begin
    next_inhibit = inhibit;
    if (count_write)
      next_inhibit = etc_pkg::WRITE_INHIBIT_CYCLES;
    else if (inst_tick && inhibit != 2'h0)
      next_inhibit = inhibit - 2'h1;
  end

  always_comb
  begin
    next_pending = pending;
    if (count_write)
      next_pending = 1'b0;
    else if (option_config.clock_select && timer_event)
      next_pending = 1'b1;
    else if (step)
      next_pending = 1'b0;
  end

  always_comb
  begin
    next_intctl = interrupt_control;
    if (wr_access && hit_intctl)
      next_intctl = pwdata[7:0];
    if (overflow)
      next_intctl[etc_pkg::OVF_FLAG_BIT] = 1'b1;
  end

  always_comb
  begin
    next_status = irq_status;
    if (rd_access && hit_status)
      next_status = 8'h00;
    next_status = next_status | events;
  end

  // phase counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= etc_pkg::PHASE_Q1;
    else
      phase <= phase + 2'h1;
  end

  // timer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_register <= etc_pkg::COUNT_RESET;
      inhibit <= 2'h0;
      pending <= 1'b0;
    end
    else
    begin
      count_register <= next_count;
      inhibit <= next_inhibit;
      pending <= next_pending;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      option_config <= etc_pkg::OPTION_RESET;
      interrupt_control <= etc_pkg::INTCTL_RESET;
      irq_status <= etc_pkg::STATUS_RESET;
      irq_mask <= etc_pkg::MASK_RESET;
    end
    else
    begin
      if (wr_access && hit_option)
        option_config <= pwdata[7:0];
      if (wr_access && hit_mask)
        irq_mask <= pwdata[7:0];
      interrupt_control <= next_intctl;
      irq_status <= next_status;
    end
  end

  // apb answer, one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~mapped;
      prdata <= {24'h000000, read_mux};
    end
  end

  // outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_irq <= 1'b0;
      irq <= 1'b0;
      watchdog_event <= 1'b0;
    end
    else
    begin
      timer_irq <= next_intctl[etc_pkg::OVF_FLAG_BIT] &
                   next_intctl[etc_pkg::IRQ_ENABLE_BIT];
      irq <= |(next_status & irq_mask);
      watchdog_event <= to_timer ? watchdog_tick : psc_out;
    end
  end

endmodule

// >>> core/etc_pkg.sv
package etc_pkg;

  // register byte offsets
  localparam logic [7:0] COUNT_OFFSET = 8'h00;
  localparam logic [7:0] OPTION_OFFSET = 8'h04;
  localparam logic [7:0] INTCTL_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] MASK_OFFSET = 8'h10;

  // values after reset
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // interrupt_control field positions
  localparam int IRQ_ENABLE_BIT = 5;
  localparam int OVF_FLAG_BIT = 2;

  // status and mask field positions
  localparam int EVT_OVERFLOW_BIT = 0;
  localparam int EVT_EXT_EDGE_BIT = 1;

  // cycle phases, write inhibit length and count top
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
  localparam logic [7:0] COUNT_TOP = 8'hFF;

  // option_config layout
  typedef struct packed {
    logic [1:0] spare;
    logic clock_select;
    logic edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
  } etc_option_type;

  // apb request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } etc_apb_req_type;

endpackage

// >>> core/etc_prescaler.sv
`timescale 1ns/100ps

module etc_prescaler #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic event_in,
  input wire logic [2:0] ratio,
  // divided event
  output logic event_out
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  wire [WIDTH-1:0] tap_mask;
  wire tap_full;

  // ratio 0 divides by 2, ratio 7 by 256
  assign tap_mask = WIDTH'((32'h2 << ratio) - 32'h1);
  assign tap_full = (count & tap_mask) == tap_mask;
  assign event_out = event_in & tap_full;

  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = '0;
    else if (event_in)
      next_count = count + WIDTH'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else
      count <= next_count;
  end

endmodule

// >>> core/etc_edge_sync.sv
`timescale 1ns/100ps

module etc_edge_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and polarity
  input wire logic pin,
  input wire logic falling,
  // one-cycle edge pulse
  output logic edge_seen
);

  logic meta;
  logic stable;
  logic last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= pin;
      stable <= meta;
      last <= stable;
    end
  end

  assign edge_seen = falling ? (last & ~stable) : (stable & ~last);

endmodule

// >>> bench/etc_timer_asserts.sv
`timescale 1ns/100ps
module etc_timer_asserts (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // timer side
  input wire logic sleep_mode,
  input wire logic timer_irq,
  input wire logic irq
);
  wire acc;
  wire wr_ctl;
  wire mapped;
  assign acc = psel && penable && pready;
  assign wr_ctl = acc && pwrite && paddr == etc_pkg::INTCTL_OFFSET;
  assign mapped = paddr <= etc_pkg::MASK_OFFSET && paddr[1:0] == 2'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_source: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_rdata: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr with data");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_flag_sw_clear: assert property ($fell(timer_irq) |-> $past(wr_ctl))
    else $error("timer irq fell without write");
  a_irq_sw_clear: assert property ($fell(irq) |-> $past(acc) || $past(acc, 2))
    else $error("irq fell without access");
  a_sleep_frozen: assert property ((sleep_mode && !psel)[*3] |-> $stable(timer_irq))
    else $error("timer irq moved in sleep");
endmodule

bind etc_timer etc_timer_asserts u_etc_timer_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_mode(sleep_mode), .timer_irq(timer_irq),
  .irq(irq)
);

// >>> bench/etc_pin_model.sv
`timescale 1ns/100ps
module etc_pin_model (
  // clock
  input wire logic pclk,
  // pulse request
  input wire logic start,
  input wire logic [3:0] pulses,
  input wire logic idle_level,
  // count pin
  output logic pin
);
  logic [3:0] left = 4'h0;
  logic [2:0] ph = 3'h0;
  // pin rests at idle_level; each pulse is 4 cycles at idle_level, then 4 inverted
  assign pin = (left != 4'h0) ? idle_level ^ ph[2] : idle_level;
  always @(posedge pclk)
  begin
    if (start)
    begin
      left <= pulses;
      ph <= 3'h0;
    end
    else if (left != 4'h0)
    begin
      ph <= ph + 3'h1;
      if (ph == 3'h7)
        left <= left - 4'h1;
    end
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("MISMATCH %0t got %h exp %h", $time, g, e); \
    end \
  end
module testbench;
  localparam logic [7:0] CNT = etc_pkg::COUNT_OFFSET;
  localparam logic [7:0] OPT = etc_pkg::OPTION_OFFSET;
  localparam logic [7:0] CTL = etc_pkg::INTCTL_OFFSET;
  localparam logic [7:0] STA = etc_pkg::STATUS_OFFSET;
  localparam logic [7:0] MSK = etc_pkg::MASK_OFFSET;
  logic pclk, presetn, psel, penable, pwrite, sleep_mode;
  logic watchdog_tick, watchdog_clear, watchdog_event, timer_irq, irq;
  logic pready, pslverr, start, idle_level, rerr;
  logic [7:0] paddr, rv;
  logic [31:0] pwdata, prdata;
  wire pin_w;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  etc_timer #(.PRESCALE_WIDTH(8)) u_etc_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_input(pin_w),
    .sleep_mode(sleep_mode), .watchdog_tick(watchdog_tick),
    .watchdog_clear(watchdog_clear), .watchdog_event(watchdog_event),
    .timer_irq(timer_irq), .irq(irq));
  etc_pin_model u_etc_pin_model (.pclk(pclk), .start(start),
    .pulses(4'h5), .idle_level(idle_level), .pin(pin_w));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rv, e)
  endtask
  task t_regs;
    rd_chk(CNT, etc_pkg::COUNT_RESET);
    rd_chk(OPT, etc_pkg::OPTION_RESET);
    rd_chk(CTL, etc_pkg::INTCTL_RESET);
    rd_chk(STA, etc_pkg::STATUS_RESET);
    rd_chk(MSK, etc_pkg::MASK_RESET);
    wr(CTL, 8'h5B);
    rd_chk(CTL, 8'h5B);
    rd_chk(8'h14, 8'h00);
    `CHK(rerr, 1'b1)
    $display("test regs done");
  endtask
  task t_overflow;
    int n;
    int t1;
    wr(OPT, 8'h08);
    wr(MSK, 8'h01);
    wr(CTL, 8'h20);
    wr(CNT, 8'hFF);
    for (n = 0; n < 40 && timer_irq !== 1'b1; n++)
      @(posedge pclk);
    `CHK(n >= 11 && n <= 14, 1'b1)
    `CHK(irq, 1'b1)
    t1 = cyc;
    rd_chk(STA, 8'h01);
    wr(CTL, 8'h00);
    for (n = 0; n < 1100 && irq !== 1'b1; n++)
      @(posedge pclk);
    `CHK(cyc - t1, 1024)
    rd_chk(CTL, 8'h04);
    `CHK(timer_irq, 1'b0)
    wr(MSK, 8'h00);
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    wr(MSK, 8'h01);
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b1)
    rd_chk(STA, 8'h01);
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    $display("test overflow done");
  endtask
  task t_ratio;
    int r;
    int dv;
    logic [7:0] a;
    for (r = 0; r < 9; r++)
    begin
      dv = (r == 8) ? 1 : 2 << r;
      watchdog_clear <= 1'b1;
      @(posedge pclk);
      watchdog_clear <= 1'b0;
      wr(CNT, 8'h00);
      wr(OPT, (r == 8) ? 8'h08 : 8'(r));
      repeat (8) @(posedge pclk);
      apb(1'b0, CNT, 8'h00);
      a = rv;
      repeat (12 * dv - 3) @(posedge pclk);
      apb(1'b0, CNT, 8'h00);
      `CHK(rv - a, 8'h03)
    end
    $display("test ratio done");
  endtask
  task t_clear;
    wr(OPT, 8'h07);
    repeat (4)
    begin
      wr(CNT, 8'h00);
      repeat (600) @(posedge pclk);
      rd_chk(CNT, 8'h00);
    end
    $display("test clear done");
  endtask
  task t_sleep;
    wr(OPT, 8'h08);
    sleep_mode <= 1'b1;
    apb(1'b0, CNT, 8'h00);
    repeat (37) @(posedge pclk);
    rd_chk(CNT, rv);
    sleep_mode <= 1'b0;
    $display("test sleep done");
  endtask
  task t_counter;
    int es;
    for (es = 0; es < 2; es++)
    begin
      wr(OPT, es[0] ? 8'h38 : 8'h28);
      repeat (16) @(posedge pclk);
      apb(1'b0, CNT, 8'h00);
      idle_level <= 1'b1;
      repeat (16) @(posedge pclk);
      rd_chk(CNT, rv + {7'h0, ~es[0]});
      idle_level <= 1'b0;
      repeat (16) @(posedge pclk);
      rd_chk(CNT, rv + {7'h0, es[0]});
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      repeat (60) @(posedge pclk);
      rd_chk(CNT, rv + 8'h05);
    end
    $display("test counter done");
  endtask
  task t_wdog;
    wr(OPT, 8'h00);
    watchdog_tick <= 1'b1;
    @(posedge pclk);
    watchdog_tick <= 1'b0;
    @(negedge pclk);
    `CHK(watchdog_event, 1'b1)
    wr(OPT, 8'h08);
    watchdog_clear <= 1'b1;
    @(posedge pclk);
    watchdog_clear <= 1'b0;
    watchdog_tick <= 1'b1;
    @(posedge pclk);
    watchdog_tick <= 1'b0;
    @(negedge pclk);
    `CHK(watchdog_event, 1'b0)
    @(posedge pclk);
    watchdog_tick <= 1'b1;
    @(posedge pclk);
    watchdog_tick <= 1'b0;
    @(negedge pclk);
    `CHK(watchdog_event, 1'b1)
    $display("test watchdog done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    print_verdict;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_mode = 1'b0;
    watchdog_tick = 1'b0;
    watchdog_clear = 1'b0;
    start = 1'b0;
    idle_level = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_overflow;
    t_ratio;
    t_clear;
    t_sleep;
    t_counter;
    t_wdog;
    print_verdict;
  end
endmodule
